//--- tmwoc_consts.vh
// Overview of operation
// R1 - Nonzero action field routes compare output to pin
// R2 - Software sets pin direction to output
// R3 - Channel A non-PWM: off, toggle, clear, set
// R4 - Fast PWM A: 10 non-inverting, 11 inverting
// R5 - PWM A action 01 toggles only with hi bit
// R6 - Fast PWM compare equals TOP: act at BOTTOM
// R7 - Phase-correct A: 10 clear up, set down
// R8 - Phase-correct compare equals TOP: act at TOP
// R9 - Channel B non-PWM decodes like channel A
// R10 - Fast PWM B: 01 reserved, 10/11 as A
// R11 - Phase-correct B: 01 reserved, 10/11 as A
// R12 - Control bits 3 and 2 read zero
// R13 - Mode selector joins hi bit and low bits
// R14 - Mode encodings and TOP sources per mode
// R15 - Compare update and overflow point per mode
// R16 - MAX is 0xFF and BOTTOM is 0x00
`ifndef TMWOC_CONSTS_VH
`define TMWOC_CONSTS_VH
// ==========================================================
// Register map
`define TMWOC_ADDR_CTRL_A   8'h30
`define TMWOC_ADDR_CTRL_B   8'h33
`define TMWOC_ADDR_CNT      8'h32
`define TMWOC_ADDR_CMP_A    8'h36
`define TMWOC_ADDR_CMP_B    8'h3C
`define TMWOC_ADDR_IRQ_MASK 8'h39
`define TMWOC_ADDR_IRQ_STAT 8'h38
`define TMWOC_CTRL_A_RST    8'h00
`define TMWOC_CTRL_A_WMASK  8'hF3
`define TMWOC_CTRL_B_WMASK  8'h08
`define TMWOC_IRQ_WMASK     8'h07
// ==========================================================
// Field positions
`define TMWOC_A_ACT_HI      7
`define TMWOC_A_ACT_LO      6
`define TMWOC_B_ACT_HI      5
`define TMWOC_B_ACT_LO      4
`define TMWOC_WAVE_HI_POS   3
`define TMWOC_FORCE_A_POS   7
`define TMWOC_FORCE_B_POS   6
`define TMWOC_STAT_OVF      0
`define TMWOC_STAT_CMPA     1
`define TMWOC_STAT_CMPB     2
// ==========================================================
// Counter limits and mode codes
`define TMWOC_MAX           8'hFF
`define TMWOC_BOTTOM        8'h00
`define TMWOC_MODE_NORMAL   3'h0
`define TMWOC_MODE_PC_FF    3'h1
`define TMWOC_MODE_CTC      3'h2
`define TMWOC_MODE_FAST_FF  3'h3
`define TMWOC_MODE_PC_A     3'h5
`define TMWOC_MODE_FAST_A   3'h7
`endif

//--- tmwoc_out_chan.v
`include "tmwoc_consts.vh"
// Waveform logic for one compare-output channel
module tmwoc_out_chan #(
  parameter TOGGLE_IN_PWM = 1
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Mode decode
  input  wire       is_fast,
  input  wire       is_pc,
  input  wire       wave_hi,
  input  wire [1:0] action,
  // Timer events
  input  wire       match,
  input  wire       at_bottom,
  input  wire       at_top,
  input  wire       counting_up,
  input  wire       cmp_is_top,
  input  wire       force_cmp,
  // Output
  output reg        wave,
  output wire       pin_en
);
  reg next_wave;

  // ==========================================================
  // Output override
  assign pin_en = |action; // [R1]

  // ==========================================================
  // Next waveform value
  always @* begin
    next_wave = wave;
    if (is_fast) begin
      if (action[1]) begin
        // A match on TOP would collide with the BOTTOM action
        if (at_bottom) begin
          next_wave = ~action[0]; // [R4] [R10] [R6]
        end else if (match && !cmp_is_top) begin
          next_wave = action[0]; // [R4] [R10]
        end
      end else if (action == 2'b01 && TOGGLE_IN_PWM && wave_hi && match) begin
        next_wave = ~wave; // [R5]
      end
    end else if (is_pc) begin
      if (action[1]) begin
        // At TOP the pin takes the down-count level, so the wave stays symmetric
        if (cmp_is_top && at_top) begin
          next_wave = ~action[0]; // [R8]
        end else if (match && !cmp_is_top) begin
          next_wave = counting_up ? action[0] : ~action[0]; // [R7] [R11]
        end
      end else if (action == 2'b01 && TOGGLE_IN_PWM && wave_hi && match) begin
        next_wave = ~wave; // [R5]
      end
    end else if (match || force_cmp) begin
      case (action)
        2'b01: next_wave = ~wave; // [R3] [R9]
        2'b10: next_wave = 1'b0;
        2'b11: next_wave = 1'b1;
        default: next_wave = wave;
      endcase
    end
  end

  // Output register
  always @(posedge clk) begin
    if (rst) begin
      wave <= 1'b0;
    end else begin
      wave <= next_wave;
    end
  end
endmodule

//--- tmwoc_top.v
`include "tmwoc_consts.vh"
// 8-bit timer with waveform control and two compare outputs
module tmwoc_top (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // Timer tick
  input  wire       tick,
  // Compare outputs
  output wire       cmp_out_a,
  output wire       cmp_out_a_en,
  output wire       cmp_out_b,
  output wire       cmp_out_b_en,
  // Interrupt
  output wire       irq
);
  reg  [7:0] timer_wave_control_a;
  reg        wave_mode_hi_bit;
  reg  [7:0] count;
  reg        counting_up;
  reg  [7:0] cmp_val_a;
  reg  [7:0] cmp_val_b;
  reg  [7:0] cmp_buf_a;
  reg  [7:0] cmp_buf_b;
  reg  [2:0] irq_mask;
  reg  [2:0] irq_stat;
  reg  [7:0] next_count;
  reg        next_up;
  reg        force_a;
  reg        force_b;
  wire [2:0] wave_mode_sel;
  wire [1:0] out_a_action;
  wire [1:0] out_b_action;
  wire       is_fast;
  wire       is_pc;
  wire       top_is_a;
  wire [7:0] top_val;
  wire       at_top;
  wire       at_bottom;
  wire       at_max;
  wire       match_a;
  wire       match_b;
  wire       upd_now;
  wire       upd_top;
  wire       upd_bot;
  wire       ovf_evt;
  reg        cnt_wr;
  wire       to_bottom;
  wire [2:0] stat_clr;

  // Selects the register for a write at the given address
  function wr_hit;
    input [7:0] a;
    input [7:0] ref_addr;
    begin
      wr_hit = wr && (a == ref_addr);
    end
  endfunction

  // ==========================================================
  // Mode decode
  assign out_a_action  = timer_wave_control_a[`TMWOC_A_ACT_HI:`TMWOC_A_ACT_LO];
  assign out_b_action  = timer_wave_control_a[`TMWOC_B_ACT_HI:`TMWOC_B_ACT_LO];
  assign wave_mode_sel = {wave_mode_hi_bit, timer_wave_control_a[1:0]}; // [R13]
  assign is_fast  = (wave_mode_sel == `TMWOC_MODE_FAST_FF) ||
                    (wave_mode_sel == `TMWOC_MODE_FAST_A); // [R14]
  assign is_pc    = (wave_mode_sel == `TMWOC_MODE_PC_FF) ||
                    (wave_mode_sel == `TMWOC_MODE_PC_A); // [R14]
  assign top_is_a = (wave_mode_sel == `TMWOC_MODE_CTC) ||
                    (wave_mode_sel == `TMWOC_MODE_PC_A) ||
                    (wave_mode_sel == `TMWOC_MODE_FAST_A); // [R14]
  assign top_val  = top_is_a ? cmp_val_a : `TMWOC_MAX; // [R14]

  // Counter limit flags
  assign at_top    = tick && (count == top_val);
  assign at_bottom = tick && (count == `TMWOC_BOTTOM); // [R16]
  assign at_max    = tick && (count == `TMWOC_MAX); // [R16]
  // A fast count reaches BOTTOM on the tick that finds it at TOP
  assign to_bottom = at_top; // [R4] [R6]
  // A counter write blocks the match on the following tick
  assign match_a   = tick && !cnt_wr && (count == cmp_val_a);
  assign match_b   = tick && !cnt_wr && (count == cmp_val_b);

  // ==========================================================
  // Compare update point and overflow point
  assign upd_now = (wave_mode_sel == `TMWOC_MODE_NORMAL) ||
                   (wave_mode_sel == `TMWOC_MODE_CTC); // [R15]
  assign upd_top = is_pc && at_top; // [R15]
  assign upd_bot = is_fast && at_top; // [R15]
  assign ovf_evt = (wave_mode_sel == `TMWOC_MODE_FAST_A) ? at_top :
                   is_pc ? at_bottom :
                   (wave_mode_sel == `TMWOC_MODE_NORMAL ||
                    wave_mode_sel == `TMWOC_MODE_CTC ||
                    wave_mode_sel == `TMWOC_MODE_FAST_FF) ? at_max : 1'b0; // [R15]

  // ==========================================================
  // Control register writes; reserved bits never store
  always @(posedge clk) begin
    if (rst) begin
      timer_wave_control_a <= `TMWOC_CTRL_A_RST;
      wave_mode_hi_bit     <= 1'b0;
      irq_mask             <= 3'h0;
      force_a              <= 1'b0;
      force_b              <= 1'b0;
    end else begin
      force_a <= 1'b0;
      force_b <= 1'b0;
      if (wr_hit(addr, `TMWOC_ADDR_CTRL_A)) begin
        timer_wave_control_a <= wdata & `TMWOC_CTRL_A_WMASK; // [R12]
      end
      if (wr_hit(addr, `TMWOC_ADDR_CTRL_B)) begin
        wave_mode_hi_bit <= wdata[`TMWOC_WAVE_HI_POS];
        // Force strobes only act outside PWM modes
        force_a <= wdata[`TMWOC_FORCE_A_POS] && !is_fast && !is_pc;
        force_b <= wdata[`TMWOC_FORCE_B_POS] && !is_fast && !is_pc;
      end
      if (wr_hit(addr, `TMWOC_ADDR_IRQ_MASK)) begin
        irq_mask <= wdata[2:0];
      end
    end
  end

  // ==========================================================
  // Compare registers with double buffer in PWM modes
  always @(posedge clk) begin
    if (rst) begin
      cmp_buf_a <= 8'h00;
      cmp_buf_b <= 8'h00;
      cmp_val_a <= 8'h00;
      cmp_val_b <= 8'h00;
    end else begin
      if (wr_hit(addr, `TMWOC_ADDR_CMP_A)) begin
        cmp_buf_a <= wdata;
      end
      if (wr_hit(addr, `TMWOC_ADDR_CMP_B)) begin
        cmp_buf_b <= wdata;
      end
      if (upd_now) begin
        cmp_val_a <= wr_hit(addr, `TMWOC_ADDR_CMP_A) ? wdata : cmp_buf_a; // [R15]
        cmp_val_b <= wr_hit(addr, `TMWOC_ADDR_CMP_B) ? wdata : cmp_buf_b;
      end else if (upd_top || upd_bot) begin
        cmp_val_a <= cmp_buf_a; // [R15]
        cmp_val_b <= cmp_buf_b;
      end
    end
  end

  // ==========================================================
  // Count sequence per mode
  always @* begin
    next_count = count;
    next_up    = counting_up;
    if (tick) begin
      if (is_pc) begin
        if (counting_up && count == top_val) begin
          next_up    = 1'b0;
          next_count = count - 8'h01;
        end else if (!counting_up && count == `TMWOC_BOTTOM) begin
          next_up    = 1'b1;
          next_count = count + 8'h01;
        end else begin
          next_count = counting_up ? count + 8'h01 : count - 8'h01;
        end
      end else begin
        next_up    = 1'b1;
        next_count = (top_is_a || is_fast) && count == top_val ?
                     `TMWOC_BOTTOM : count + 8'h01; // [R14]
      end
    end
    if (wr_hit(addr, `TMWOC_ADDR_CNT)) begin
      next_count = wdata;
    end
  end

  // Counter register
  always @(posedge clk) begin
    if (rst) begin
      count       <= `TMWOC_BOTTOM;
      counting_up <= 1'b1;
    end else begin
      count       <= next_count;
      counting_up <= next_up;
    end
  end

  // Counter write masks the match on the next tick; software risks a missed match
  always @(posedge clk) begin
    if (rst) begin
      cnt_wr <= 1'b0;
    end else if (wr_hit(addr, `TMWOC_ADDR_CNT)) begin
      cnt_wr <= 1'b1;
    end else if (tick) begin
      cnt_wr <= 1'b0;
    end
  end

  // ==========================================================
  // Sticky status; a new event wins over a clear
  assign stat_clr = wr_hit(addr, `TMWOC_ADDR_IRQ_STAT) ? wdata[2:0] : 3'h0;
  always @(posedge clk) begin
    if (rst) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (irq_stat & ~stat_clr) | {match_b, match_a, ovf_evt};
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // ==========================================================
  // Read data, one cycle after the strobe
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `TMWOC_ADDR_CTRL_A:   rdata <= timer_wave_control_a & `TMWOC_CTRL_A_WMASK; // [R12]
        `TMWOC_ADDR_CTRL_B:   rdata <= {4'h0, wave_mode_hi_bit, 3'h0};
        `TMWOC_ADDR_CNT:      rdata <= count;
        `TMWOC_ADDR_CMP_A:    rdata <= cmp_buf_a;
        `TMWOC_ADDR_CMP_B:    rdata <= cmp_buf_b;
        `TMWOC_ADDR_IRQ_MASK: rdata <= {5'h00, irq_mask};
        `TMWOC_ADDR_IRQ_STAT: rdata <= {5'h00, irq_stat};
        default:              rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Output channels; pin drive still needs the port direction set [R2]
  tmwoc_out_chan #(.TOGGLE_IN_PWM(1)) u_chan_a (
    .clk         (clk),
    .rst         (rst),
    .is_fast     (is_fast),
    .is_pc       (is_pc),
    .wave_hi     (wave_mode_hi_bit),
    .action      (out_a_action),
    .match       (match_a),
    .at_bottom   (to_bottom),
    .at_top      (at_top),
    .counting_up (counting_up),
    .cmp_is_top  (cmp_val_a == top_val),
    .force_cmp   (force_a),
    .wave        (cmp_out_a),
    .pin_en      (cmp_out_a_en)
  );

  // Channel B has no toggle in PWM modes
  tmwoc_out_chan #(.TOGGLE_IN_PWM(0)) u_chan_b (
    .clk         (clk),
    .rst         (rst),
    .is_fast     (is_fast),
    .is_pc       (is_pc),
    .wave_hi     (wave_mode_hi_bit),
    .action      (out_b_action),
    .match       (match_b),
    .at_bottom   (to_bottom),
    .at_top      (at_top),
    .counting_up (counting_up),
    .cmp_is_top  (cmp_val_b == top_val),
    .force_cmp   (force_b),
    .wave        (cmp_out_b),
    .pin_en      (cmp_out_b_en)
  );
endmodule

//--- tmwoc_top_bench.sv
`include "tmwoc_consts.vh"
// ====
// Self-checking bench for the waveform timer
module tmwoc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       tick = 1'b0;
  wire  [7:0] rdata;
  wire        out_a;
  wire        en_a;
  wire        out_b;
  wire        en_b;
  wire        irq;
  int         fails = 0;
  int         comparisons = 0;
  tmwoc_top i_tmwoc_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tick(tick), .cmp_out_a(out_a), .cmp_out_a_en(en_a),
    .cmp_out_b(out_b), .cmp_out_b_en(en_b), .irq(irq));
  // ====
  // Clock, 40 ns period
  initial forever #20 clk = ~clk;
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // One-cycle strobes; the #1 lets the edge's updates land
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Ticks every cycle; counts high cycles over n cycles, one or more full periods
  task automatic duty(input int warm, input int n, input int ea, input int eb);
    int ha;
    int hb;
    ha = 0;
    hb = 0;
    @(posedge clk);
    tick <= 1'b1;
    repeat (warm) @(posedge clk);
    repeat (n) begin
      @(posedge clk);
      #1;
      ha += out_a;
      hb += out_b;
    end
    check("duty a", ha[9:0], ea[9:0]);
    check("duty b", hb[9:0], eb[9:0]);
  endtask
  // Pin direction sits outside the block; the enables are what it would gate
  task automatic t_regs;
    logic [7:0] d;
    rreg(`TMWOC_ADDR_CTRL_A, d);
    check("ctrl reset", d, 8'h00);
    wreg(`TMWOC_ADDR_CTRL_A, 8'hFF);
    check("en a", en_a, 1'b1);
    rreg(`TMWOC_ADDR_CTRL_A, d);
    check("ctrl read", d, 8'hF3);
    wreg(`TMWOC_ADDR_CTRL_A, 8'h10);
    check("en a off", en_a, 1'b0);
    check("en b", en_b, 1'b1);
    rreg(8'h3F, d);
    check("unmapped", d, 8'h00);
  endtask
  // Overflow flag, mask and write-one clear
  task automatic t_irq;
    logic [7:0] d;
    wreg(`TMWOC_ADDR_CTRL_A, 8'h00);
    @(posedge clk);
    tick <= 1'b1;
    repeat (300) @(posedge clk);
    tick <= 1'b0;
    rreg(`TMWOC_ADDR_IRQ_STAT, d);
    check("ovf flag", d[0], 1'b1);
    check("irq masked", irq, 1'b0);
    wreg(`TMWOC_ADDR_IRQ_MASK, 8'h01);
    check("irq on", irq, 1'b1);
    wreg(`TMWOC_ADDR_IRQ_STAT, 8'h07);
    rreg(`TMWOC_ADDR_IRQ_STAT, d);
    check("stat clear", d, 8'h00);
    check("irq off", irq, 1'b0);
  endtask
  // Forced matches in normal mode: toggle, clear, set, toggle
  task automatic t_force;
    logic       ea;
    logic [1:0] c;
    ea = 1'b0;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i % 3 + 1);
      wreg(`TMWOC_ADDR_CTRL_A, {c, c, 4'h0});
      wreg(`TMWOC_ADDR_CTRL_B, 8'hC0);
      repeat (3) @(posedge clk);
      #1;
      ea = (c == 2'b01) ? !ea : c[0];
      check("force a", out_a, ea);
      check("force b", out_b, ea);
    end
  endtask
  // Duty in fast and phase-correct PWM on both channels, including a compare value at TOP
  task automatic t_pwm;
    wreg(`TMWOC_ADDR_CMP_A, 8'h80);
    wreg(`TMWOC_ADDR_CMP_B, 8'h40);
    wreg(`TMWOC_ADDR_CTRL_A, 8'hB3);
    duty(300, 256, 129, 191);
    wreg(`TMWOC_ADDR_CMP_B, 8'hFF);
    duty(600, 256, 129, 0);
    wreg(`TMWOC_ADDR_CMP_B, 8'h40);
    wreg(`TMWOC_ADDR_CTRL_A, 8'hB1);
    duty(1100, 510, 256, 382);
    wreg(`TMWOC_ADDR_CMP_A, 8'hFF);
    duty(1100, 510, 510, 382);
    wreg(`TMWOC_ADDR_CTRL_A, 8'h51);
    repeat (300) @(posedge clk);
  endtask
  // TOP from compare A: toggle on A, count held at or below TOP, overflow at TOP
  task automatic t_top_a;
    logic [7:0] d;
    wreg(`TMWOC_ADDR_CMP_A, 8'h3F);
    wreg(`TMWOC_ADDR_CMP_B, 8'h10);
    wreg(`TMWOC_ADDR_CTRL_A, 8'h63);
    wreg(`TMWOC_ADDR_CTRL_B, 8'h08);
    duty(600, 128, 64, 34);
    rreg(`TMWOC_ADDR_CNT, d);
    check("top a", d <= 8'h3F, 1'b1);
    wreg(`TMWOC_ADDR_IRQ_STAT, 8'h07);
    repeat (70) @(posedge clk);
    rreg(`TMWOC_ADDR_IRQ_STAT, d);
    check("ovf at top", d[0], 1'b1);
  endtask
  task automatic conclude;
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog, well beyond the few thousand cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_irq();
    t_force();
    t_pwm();
    t_top_a();
    conclude();
  end
endmodule

//--- tmwoc_top_sva.sv
`include "tmwoc_consts.vh"
// ====
// Port checker for the waveform timer
module tmwoc_chk (
  // Clock and reset
  input logic       clk,
  input logic       rst,
  // Register port
  input logic [7:0] addr,
  input logic [7:0] wdata,
  input logic       wr,
  input logic       rd,
  input logic [7:0] rdata,
  input logic       tick,
  // Outputs
  input logic       cmp_out_a,
  input logic       cmp_out_a_en,
  input logic       cmp_out_b,
  input logic       cmp_out_b_en,
  input logic       irq
);
  logic [7:0] ctrl_sh;
  logic       hi_sh;
  logic [2:0] mask_sh;
  // Shadow registers, updated on the same edge as the design's
  always @(posedge clk) begin
    if (rst) begin
      ctrl_sh <= 8'h00;
      hi_sh   <= 1'b0;
      mask_sh <= 3'h0;
    end else if (wr) begin
      if (addr == `TMWOC_ADDR_CTRL_A) ctrl_sh <= wdata & `TMWOC_CTRL_A_WMASK;
      if (addr == `TMWOC_ADDR_CTRL_B) hi_sh <= wdata[`TMWOC_WAVE_HI_POS];
      if (addr == `TMWOC_ADDR_IRQ_MASK) mask_sh <= wdata[2:0];
    end
  end
  // Odd mode codes are the PWM modes; reserved ones are even
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_CTRL_READ: assert property (
    $past(rd) && $past(addr) == `TMWOC_ADDR_CTRL_A |-> rdata == $past(ctrl_sh))
    else $error("control read back wrong");
  AST_EN_A: assert property (cmp_out_a_en == (ctrl_sh[7:6] != 2'b00))
    else $error("channel a pin override wrong");
  AST_EN_B: assert property (cmp_out_b_en == (ctrl_sh[5:4] != 2'b00))
    else $error("channel b pin override wrong");
  AST_HOLD_A: assert property ((!tick && !wr)[*3] |=> $stable(cmp_out_a))
    else $error("channel a moved without cause");
  AST_HOLD_B: assert property ((!tick && !wr)[*3] |=> $stable(cmp_out_b))
    else $error("channel b moved without cause");
  AST_B_RSV: assert property (
    ctrl_sh[0] && ctrl_sh[5:4] == 2'b01 |=> $stable(cmp_out_b))
    else $error("channel b acted on reserved code");
  AST_A_OFF: assert property (
    ctrl_sh[0] && !hi_sh && ctrl_sh[7:6] == 2'b01 |=> $stable(cmp_out_a))
    else $error("channel a toggled without mode bit");
  AST_FORCE_A: assert property (wr && addr == `TMWOC_ADDR_CTRL_B && wdata[7]
    && !wdata[3] && !ctrl_sh[0] && ctrl_sh[7:6] == 2'b11 |-> ##[1:2] cmp_out_a)
    else $error("forced set on channel a missing");
  AST_FORCE_B: assert property (wr && addr == `TMWOC_ADDR_CTRL_B && wdata[6]
    && !wdata[3] && !ctrl_sh[0] && ctrl_sh[5:4] == 2'b10 |-> ##[1:2] !cmp_out_b)
    else $error("forced clear on channel b missing");
  AST_IRQ_MASK: assert property (mask_sh == 3'h0 && $past(mask_sh) == 3'h0 |-> !irq)
    else $error("interrupt raised while fully masked");
endmodule

bind tmwoc_top tmwoc_chk i_tmwoc_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .tick(tick), .cmp_out_a(cmp_out_a), .cmp_out_a_en(cmp_out_a_en),
  .cmp_out_b(cmp_out_b), .cmp_out_b_en(cmp_out_b_en), .irq(irq));
